/* hw/tbp_pkg.sv */
package tbp_pkg;
    localparam int CNT_W = 10;
    localparam int DAT_W = 8;
    localparam int ADR_W = 5;
    localparam int NUM_TMR = 2;
    localparam int NUM_CH = 2;
    localparam int HI_W = 2;

    localparam logic [CNT_W-1:0] CNT_ZERO = 10'h000;
    localparam logic [CNT_W-1:0] CNT_ONE  = 10'h001;
    localparam logic [CNT_W-1:0] CNT_MAX  = 10'h3FF;
    localparam logic [7:0]       PSC_ONE  = 8'h01;
    localparam logic [8:0]       PSC_BASE = 9'h002;
    localparam logic [8:0]       PSC_SUB  = 9'h001;

    // Register offsets.
    localparam logic [ADR_W-1:0] ADR_A_HIGH = 5'h00;
    localparam logic [ADR_W-1:0] ADR_B_DUTY = 5'h01;
    localparam logic [ADR_W-1:0] ADR_B_CTL  = 5'h02;
    localparam logic [ADR_W-1:0] ADR_C_DUTY = 5'h03;
    localparam logic [ADR_W-1:0] ADR_C_CTL  = 5'h04;
    localparam logic [ADR_W-1:0] ADR_IRQ2   = 5'h11;
    localparam logic [ADR_W-1:0] ADR_IFLG3  = 5'h12;
    localparam logic [ADR_W-1:0] ADR_IEN3   = 5'h13;
    localparam logic [ADR_W-1:0] TMR_BASE [NUM_TMR] = '{5'h05, 5'h0B};
    localparam logic [ADR_W-1:0] OFS_HIGH = 5'h00;
    localparam logic [ADR_W-1:0] OFS_LOW  = 5'h01;
    localparam logic [ADR_W-1:0] OFS_CTL1 = 5'h02;
    localparam logic [ADR_W-1:0] OFS_CTL2 = 5'h03;
    localparam logic [ADR_W-1:0] OFS_PSCV = 5'h04;
    localparam logic [ADR_W-1:0] OFS_DUTY = 5'h05;

    // Field positions.
    localparam int BIT_OUT_EN   = 7;
    localparam int BIT_ACT_LOW  = 6;
    localparam int BIT_FAST     = 3;
    localparam int BIT_ONE_SHOT = 2;
    localparam int BIT_RLD_SEL  = 1;
    localparam int BIT_RUN      = 0;
    localparam int BIT_SRC      = 5;
    localparam int BIT_EDGE     = 4;
    localparam int BIT_PSC_N    = 3;
    localparam int RATIO_LSB    = 0;
    localparam int RATIO_W      = 3;
    localparam int RLD_LSB  [NUM_TMR] = '{6, 4};
    localparam int DUTY_LSB [NUM_TMR] = '{2, 0};
    localparam int PB_DUTY_LSB = 2;
    localparam int PC_DUTY_LSB = 0;
    localparam int BIT_FLAG_D  = 6;
    localparam int BIT_IEN_D   = 2;
    localparam int BIT_FLAG_E  = 5;
    localparam int BIT_IEN_E   = 5;
    localparam int TMR_D = 0;
    localparam int TMR_E = 1;
    localparam int CH_B  = 0;
    localparam int CH_C  = 1;

    typedef struct packed {
        logic             outEn;
        logic             actLow;
        logic [CNT_W-1:0] dutyBuf;
        logic [CNT_W-1:0] dutyAct;
    } tbp_chan_type;

    typedef struct packed {
        tbp_chan_type       pwm;
        logic               run;
        logic               fastOsc;
        logic               oneShot;
        logic               reloadSel;
        logic               srcSel;
        logic               edgeSel;
        logic               pscN;
        logic [RATIO_W-1:0] ratio;
        logic [CNT_W-1:0]   reload;
        logic [CNT_W-1:0]   count;
        logic [7:0]         psc;
    } tbp_timer_type;

    typedef struct packed {
        logic [1:0] bOut;
        logic [1:0] bOe;
        logic [1:0] cOut;
        logic [1:0] cOe;
        logic       dOut;
        logic       dOe;
        logic       eOut;
        logic       eOe;
    } tbp_pins_type;

    localparam tbp_chan_type  CHAN_RST  = '0;
    localparam tbp_timer_type TIMER_RST = '0;
    localparam tbp_pins_type  PINS_RST  = '0;
endpackage

/* hw/tbp_ten_bit_timers.sv */
// Implementation choices: the plain strobed port and the address map.
`timescale 1ns/10ps
// Notes on behaviour
// - Channel B drives selected pin when enabled
// - Channel B duty ten bits, zero never active
// - Channel B duty applies on timer A overflow
// - Channel C drives option-selected pin, polarity bit
// - Channel C duty high bits in D register
// - Channel C duty applies on timer A overflow
// - Timer D reload buffered, stopped loads immediately
// - Timer D runs when enabled, source select
// - External edge select: falling or rising
// - Prescaler divides 1:2 to 1:256, readable
// - One-shot counts down once then stops
// - Non-stop restarts from reload or maximum
// - Timer D underflow sets sticky flag, request
// - Channel D drives fixed pin when enabled
// - Channel D duty applies on timer D underflow
// - Timer E reload buffered, stopped loads immediately
// - Timer E runs when enabled, source select
// - Timer E behaves like timer D
// - Timer E underflow sets sticky flag, request
// - Channel E drives fixed pin when enabled
// - Channel E duty applies on timer E underflow
// - Timer A count and overflow feed B, C
module tbp_ten_bit_timers
    import tbp_pkg::*;
(
    input  wire logic             mclk,
    input  wire logic             sys_rst,
    input  wire logic [ADR_W-1:0] regAddr,
    input  wire logic [DAT_W-1:0] regWrData,
    input  wire logic             regWrStrobe,
    input  wire logic             regRdStrobe,
    output logic      [DAT_W-1:0] regRdData_ff,
    input  wire logic             instrTick,
    input  wire logic             internalFastOscillator,
    input  wire logic             externalCountPin,
    input  wire logic             globalIrqEnable,
    input  wire logic             pwmBPinSel,
    input  wire logic             pwmCPinSel,
    input  wire logic [CNT_W-1:0] timerACount,
    input  wire logic             timerAOverflow,
    output tbp_pins_type          pwmPins_ff,
    output logic                  timerDIrq_ff,
    output logic                  timerEIrq_ff
);

    tbp_timer_type    tmr_ff [NUM_TMR];
    tbp_timer_type    nxt_tmr [NUM_TMR];
    tbp_chan_type     chan_ff [NUM_CH];
    tbp_chan_type     nxt_chan [NUM_CH];
    logic             extPinDly_ff;
    logic             nxt_extPinDly;
    logic             flagD_ff;
    logic             nxt_flagD;
    logic             enD_ff;
    logic             nxt_enD;
    logic             flagE_ff;
    logic             nxt_flagE;
    logic             enE_ff;
    logic             nxt_enE;
    logic             nxt_timerDIrq;
    logic             nxt_timerEIrq;
    tbp_pins_type     nxt_pwmPins;
    logic [DAT_W-1:0] nxt_regRdData;
    logic             extRise;
    logic             extFall;
    logic [1:0]       srcTick;
    logic [1:0]       stepTick;
    logic [1:0]       underflow;

    function automatic logic [ADR_W-1:0] tAdr(input int idx, input logic [ADR_W-1:0] ofs);
        return ADR_W'(TMR_BASE[idx] + ofs);
    endfunction

    function automatic logic [7:0] pscMask(input logic [RATIO_W-1:0] ratio);
        logic [8:0] span;
        span = (PSC_BASE << ratio) - PSC_SUB;
        return span[7:0];
    endfunction

    // Pin level of a channel; the zero count closes the active part of the frame.
    function automatic logic pwmLevel(input tbp_chan_type ch, input logic [CNT_W-1:0] cnt);
        logic active;
        active = (cnt != CNT_ZERO) && (cnt <= ch.dutyAct);
        return ch.outEn && (active ^ ch.actLow);
    endfunction

    function automatic logic [DAT_W-1:0] place2(input logic [HI_W-1:0] bits, input int lsb);
        logic [DAT_W-1:0] wide;
        wide = {6'h00, bits} << lsb;
        return wide;
    endfunction

    // Timers D and E and the duty buffers of all channels.
    always_comb begin
        nxt_extPinDly = externalCountPin;
        extRise = externalCountPin && !extPinDly_ff;
        extFall = !externalCountPin && extPinDly_ff;
        nxt_tmr = tmr_ff;
        nxt_chan = chan_ff;
        srcTick = '0;
        stepTick = '0;
        underflow = '0;
        for (int i = 0; i < NUM_TMR; i++) begin
            if (tmr_ff[i].fastOsc) begin
                srcTick[i] = internalFastOscillator;
            end else if (tmr_ff[i].srcSel) begin
                srcTick[i] = tmr_ff[i].edgeSel ? extFall : extRise;
            end else begin
                srcTick[i] = instrTick;
            end
            if (tmr_ff[i].run && srcTick[i]) begin
                if (tmr_ff[i].pscN) begin
                    stepTick[i] = 1'b1;
                end else begin
                    nxt_tmr[i].psc = tmr_ff[i].psc + PSC_ONE;
                    stepTick[i] = (tmr_ff[i].psc & pscMask(tmr_ff[i].ratio))
                                  == pscMask(tmr_ff[i].ratio);
                end
            end
            if (stepTick[i]) begin
                if (tmr_ff[i].count == CNT_ZERO) begin
                    underflow[i] = 1'b1;
                    nxt_tmr[i].pwm.dutyAct = tmr_ff[i].pwm.dutyBuf;
                    if (tmr_ff[i].oneShot) begin
                        nxt_tmr[i].run = 1'b0;
                        nxt_tmr[i].count = tmr_ff[i].reload;
                    end else if (tmr_ff[i].reloadSel) begin
                        nxt_tmr[i].count = tmr_ff[i].reload;
                    end else begin
                        nxt_tmr[i].count = CNT_MAX;
                    end
                end else begin
                    nxt_tmr[i].count = tmr_ff[i].count - CNT_ONE;
                end
            end
            if (regWrStrobe) begin
                if (regAddr == tAdr(i, OFS_HIGH)) begin
                    nxt_tmr[i].reload[9:8] = regWrData[RLD_LSB[i] +: HI_W];
                    nxt_tmr[i].pwm.dutyBuf[9:8] = regWrData[DUTY_LSB[i] +: HI_W];
                end
                if (regAddr == tAdr(i, OFS_LOW)) begin
                    nxt_tmr[i].reload[7:0] = regWrData;
                    if (!tmr_ff[i].run) begin
                        nxt_tmr[i].count = {tmr_ff[i].reload[9:8], regWrData};
                    end
                end
                if (regAddr == tAdr(i, OFS_CTL1)) begin
                    nxt_tmr[i].pwm.outEn = regWrData[BIT_OUT_EN];
                    nxt_tmr[i].pwm.actLow = regWrData[BIT_ACT_LOW];
                    nxt_tmr[i].fastOsc = regWrData[BIT_FAST];
                    nxt_tmr[i].oneShot = regWrData[BIT_ONE_SHOT];
                    nxt_tmr[i].reloadSel = regWrData[BIT_RLD_SEL];
                    nxt_tmr[i].run = regWrData[BIT_RUN];
                end
                if (regAddr == tAdr(i, OFS_CTL2)) begin
                    nxt_tmr[i].srcSel = regWrData[BIT_SRC];
                    nxt_tmr[i].edgeSel = regWrData[BIT_EDGE];
                    nxt_tmr[i].pscN = regWrData[BIT_PSC_N];
                    nxt_tmr[i].ratio = regWrData[RATIO_LSB +: RATIO_W];
                    // A fresh ratio starts from an empty prescaler.
                    nxt_tmr[i].psc = '0;
                end
                if (regAddr == tAdr(i, OFS_DUTY)) begin
                    nxt_tmr[i].pwm.dutyBuf[7:0] = regWrData;
                end
            end
        end
        for (int k = 0; k < NUM_CH; k++) begin
            if (timerAOverflow) begin
                nxt_chan[k].dutyAct = chan_ff[k].dutyBuf;
            end
        end
        if (regWrStrobe) begin
            if (regAddr == ADR_A_HIGH) begin
                nxt_chan[CH_B].dutyBuf[9:8] = regWrData[PB_DUTY_LSB +: HI_W];
            end
            if (regAddr == tAdr(TMR_D, OFS_HIGH)) begin
                nxt_chan[CH_C].dutyBuf[9:8] = regWrData[PC_DUTY_LSB +: HI_W];
            end
            if (regAddr == ADR_B_DUTY) begin
                nxt_chan[CH_B].dutyBuf[7:0] = regWrData;
            end
            if (regAddr == ADR_C_DUTY) begin
                nxt_chan[CH_C].dutyBuf[7:0] = regWrData;
            end
            if (regAddr == ADR_B_CTL) begin
                nxt_chan[CH_B].outEn = regWrData[BIT_OUT_EN];
                nxt_chan[CH_B].actLow = regWrData[BIT_ACT_LOW];
            end
            if (regAddr == ADR_C_CTL) begin
                nxt_chan[CH_C].outEn = regWrData[BIT_OUT_EN];
                nxt_chan[CH_C].actLow = regWrData[BIT_ACT_LOW];
            end
        end
    end

    // Sticky underflow flags: a new underflow beats a clearing write.
    always_comb begin
        nxt_flagD = underflow[TMR_D] || (flagD_ff && !(regWrStrobe && regAddr == ADR_IRQ2
                    && !regWrData[BIT_FLAG_D]));
        nxt_flagE = underflow[TMR_E] || (flagE_ff && !(regWrStrobe && regAddr == ADR_IFLG3
                    && !regWrData[BIT_FLAG_E]));
        nxt_enD = (regWrStrobe && regAddr == ADR_IRQ2) ? regWrData[BIT_IEN_D] : enD_ff;
        nxt_enE = (regWrStrobe && regAddr == ADR_IEN3) ? regWrData[BIT_IEN_E] : enE_ff;
        nxt_timerDIrq = flagD_ff && enD_ff && globalIrqEnable;
        nxt_timerEIrq = flagE_ff && enE_ff && globalIrqEnable;
    end

    // Output pins.
    always_comb begin
        nxt_pwmPins = PINS_RST;
        nxt_pwmPins.bOut[pwmBPinSel] = pwmLevel(chan_ff[CH_B], timerACount);
        nxt_pwmPins.bOe[pwmBPinSel] = chan_ff[CH_B].outEn;
        nxt_pwmPins.cOut[pwmCPinSel] = pwmLevel(chan_ff[CH_C], timerACount);
        nxt_pwmPins.cOe[pwmCPinSel] = chan_ff[CH_C].outEn;
        nxt_pwmPins.dOut = pwmLevel(tmr_ff[TMR_D].pwm, tmr_ff[TMR_D].count);
        nxt_pwmPins.dOe = tmr_ff[TMR_D].pwm.outEn;
        nxt_pwmPins.eOut = pwmLevel(tmr_ff[TMR_E].pwm, tmr_ff[TMR_E].count);
        nxt_pwmPins.eOe = tmr_ff[TMR_E].pwm.outEn;
    end

    // Read data stands for the one cycle after the strobe; unmapped reads give zero.
    always_comb begin
        nxt_regRdData = '0;
        if (regRdStrobe) begin
            for (int i = 0; i < NUM_TMR; i++) begin
                if (regAddr == tAdr(i, OFS_HIGH)) begin
                    nxt_regRdData = place2(tmr_ff[i].count[9:8], RLD_LSB[i])
                                  | place2(tmr_ff[i].pwm.dutyBuf[9:8], DUTY_LSB[i]);
                    if (i == TMR_D) begin
                        nxt_regRdData[PC_DUTY_LSB +: HI_W] = chan_ff[CH_C].dutyBuf[9:8];
                    end
                end
                if (regAddr == tAdr(i, OFS_LOW)) begin
                    nxt_regRdData = tmr_ff[i].count[7:0];
                end
                if (regAddr == tAdr(i, OFS_CTL1)) begin
                    nxt_regRdData[BIT_OUT_EN] = tmr_ff[i].pwm.outEn;
                    nxt_regRdData[BIT_ACT_LOW] = tmr_ff[i].pwm.actLow;
                    nxt_regRdData[BIT_FAST] = tmr_ff[i].fastOsc;
                    nxt_regRdData[BIT_ONE_SHOT] = tmr_ff[i].oneShot;
                    nxt_regRdData[BIT_RLD_SEL] = tmr_ff[i].reloadSel;
                    nxt_regRdData[BIT_RUN] = tmr_ff[i].run;
                end
                if (regAddr == tAdr(i, OFS_CTL2)) begin
                    nxt_regRdData[BIT_SRC] = tmr_ff[i].srcSel;
                    nxt_regRdData[BIT_EDGE] = tmr_ff[i].edgeSel;
                    nxt_regRdData[BIT_PSC_N] = tmr_ff[i].pscN;
                    nxt_regRdData[RATIO_LSB +: RATIO_W] = tmr_ff[i].ratio;
                end
                if (regAddr == tAdr(i, OFS_PSCV)) begin
                    nxt_regRdData = tmr_ff[i].psc;
                end
                if (regAddr == tAdr(i, OFS_DUTY)) begin
                    nxt_regRdData = tmr_ff[i].pwm.dutyBuf[7:0];
                end
            end
            if (regAddr == ADR_A_HIGH) begin
                nxt_regRdData = place2(chan_ff[CH_B].dutyBuf[9:8], PB_DUTY_LSB);
            end
            if (regAddr == ADR_B_DUTY) begin
                nxt_regRdData = chan_ff[CH_B].dutyBuf[7:0];
            end
            if (regAddr == ADR_C_DUTY) begin
                nxt_regRdData = chan_ff[CH_C].dutyBuf[7:0];
            end
            if (regAddr == ADR_B_CTL) begin
                nxt_regRdData[BIT_OUT_EN] = chan_ff[CH_B].outEn;
                nxt_regRdData[BIT_ACT_LOW] = chan_ff[CH_B].actLow;
            end
            if (regAddr == ADR_C_CTL) begin
                nxt_regRdData[BIT_OUT_EN] = chan_ff[CH_C].outEn;
                nxt_regRdData[BIT_ACT_LOW] = chan_ff[CH_C].actLow;
            end
            if (regAddr == ADR_IRQ2) begin
                nxt_regRdData[BIT_FLAG_D] = flagD_ff;
                nxt_regRdData[BIT_IEN_D] = enD_ff;
            end
            if (regAddr == ADR_IFLG3) begin
                nxt_regRdData[BIT_FLAG_E] = flagE_ff;
            end
            if (regAddr == ADR_IEN3) begin
                nxt_regRdData[BIT_IEN_E] = enE_ff;
            end
        end
    end

    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            tmr_ff <= '{TIMER_RST, TIMER_RST};
            chan_ff <= '{CHAN_RST, CHAN_RST};
            extPinDly_ff <= 1'b0;
            flagD_ff <= 1'b0;
            enD_ff <= 1'b0;
            flagE_ff <= 1'b0;
            enE_ff <= 1'b0;
            timerDIrq_ff <= 1'b0;
            timerEIrq_ff <= 1'b0;
            pwmPins_ff <= PINS_RST;
            regRdData_ff <= '0;
        end else begin
            tmr_ff <= nxt_tmr;
            chan_ff <= nxt_chan;
            extPinDly_ff <= nxt_extPinDly;
            flagD_ff <= nxt_flagD;
            enD_ff <= nxt_enD;
            flagE_ff <= nxt_flagE;
            enE_ff <= nxt_enE;
            timerDIrq_ff <= nxt_timerDIrq;
            timerEIrq_ff <= nxt_timerEIrq;
            pwmPins_ff <= nxt_pwmPins;
            regRdData_ff <= nxt_regRdData;
        end
    end

    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (sys_rst);

    pwm_b_pin_a: assert property (##1 pwmPins_ff.bOe == ($past(chan_ff[CH_B].outEn)
        ? (2'h1 << $past(pwmBPinSel)) : 2'h0)) else $error("Channel B pin enable wrong");
    pwm_c_pin_a: assert property (##1 pwmPins_ff.cOe == ($past(chan_ff[CH_C].outEn)
        ? (2'h1 << $past(pwmCPinSel)) : 2'h0)) else $error("Channel C pin enable wrong");
    zero_duty_a: assert property (chan_ff[CH_B].dutyAct == CNT_ZERO && !chan_ff[CH_B].actLow
        |=> pwmPins_ff.bOut == 2'h0) else $error("Zero duty went active");
    duty_apply_a: assert property (timerAOverflow
        |=> chan_ff[CH_B].dutyAct == $past(chan_ff[CH_B].dutyBuf))
        else $error("Channel B duty not applied");
    pwm_c_active_a: assert property (chan_ff[CH_C].outEn && !chan_ff[CH_C].actLow
        && timerACount != CNT_ZERO && timerACount <= chan_ff[CH_C].dutyAct
        |=> pwmPins_ff.cOut != 2'h0) else $error("Channel C not active");
    flag_set_a: assert property (underflow[TMR_D] |=> flagD_ff ##1 timerDIrq_ff == ($past(enD_ff)
        && $past(globalIrqEnable))) else $error("Timer D flag or request wrong");
    flag_hold_a: assert property (flagE_ff && !(regWrStrobe && regAddr == ADR_IFLG3)
        |=> flagE_ff) else $error("Timer E flag dropped");
    one_shot_a: assert property (underflow[TMR_D] && tmr_ff[TMR_D].oneShot && !regWrStrobe
        |=> !tmr_ff[TMR_D].run) else $error("One-shot did not stop");
    free_run_a: assert property (underflow[TMR_E] && !tmr_ff[TMR_E].oneShot
        && !tmr_ff[TMR_E].reloadSel && !regWrStrobe
        |=> tmr_ff[TMR_E].count == CNT_MAX) else $error("Restart not from maximum");
    stop_load_a: assert property (regWrStrobe && regAddr == tAdr(TMR_E, OFS_LOW)
        && !tmr_ff[TMR_E].run |=> tmr_ff[TMR_E].count[7:0] == $past(regWrData))
        else $error("Stopped timer missed load");
    fall_edge_a: assert property (tmr_ff[TMR_D].run && tmr_ff[TMR_D].srcSel
        && !tmr_ff[TMR_D].fastOsc && tmr_ff[TMR_D].pscN && tmr_ff[TMR_D].edgeSel && extFall
        && tmr_ff[TMR_D].count != CNT_ZERO && !regWrStrobe
        |=> tmr_ff[TMR_D].count == $past(tmr_ff[TMR_D].count) - CNT_ONE)
        else $error("Falling edge not counted");

    cov_uf_d: cover property (underflow[TMR_D] && tmr_ff[TMR_D].reloadSel);
    cov_irq_e: cover property (underflow[TMR_E] ##[1:4] timerEIrq_ff);
    cov_psc: cover property (stepTick[TMR_D] && !tmr_ff[TMR_D].pscN);
    cov_pwm_b: cover property (pwmPins_ff.bOut != 2'h0 ##1 pwmPins_ff.bOut == 2'h0);

endmodule // tbp_ten_bit_timers

/* test/tbp_far_side.sv */
`timescale 1ns/10ps
// External count source; the pin idles low between pulses.
module tbp_far_side (
    input  wire logic mclk,
    output logic      externalCountPin
);
    initial externalCountPin = 1'b0;
    // Each pulse holds the pin high for two cycles, then low for two.
    task automatic pulse(input int n);
        repeat (n) begin
            @(posedge mclk) externalCountPin <= 1'b1;
            repeat (2) @(posedge mclk);
            externalCountPin <= 1'b0;
            repeat (2) @(posedge mclk);
        end
    endtask
endmodule // tbp_far_side

/* test/tbp_ten_bit_timers_tb_top.sv */
`timescale 1ns/10ps
module tbp_ten_bit_timers_tb_top;
    import tbp_pkg::*;
    logic             mclk = 1'b0, sys_rst = 1'b1, regWrStrobe = 1'b0, regRdStrobe = 1'b0;
    logic             instrTick = 1'b0, fastTick = 1'b0, globalIrqEnable = 1'b1;
    logic             pwmBPinSel = 1'b0, pwmCPinSel = 1'b0, timerAOverflow = 1'b0;
    logic [ADR_W-1:0] regAddr = '0;
    logic [DAT_W-1:0] regWrData = '0, regRdData_ff;
    logic [CNT_W-1:0] timerACount = 10'h105;
    logic             externalCountPin, timerDIrq_ff, timerEIrq_ff;
    tbp_pins_type     pwmPins_ff;
    int               errorCnt = 0, nCompared = 0;

    always #2.5 mclk = ~mclk;

    tbp_ten_bit_timers u_dut (.mclk(mclk), .sys_rst(sys_rst), .regAddr(regAddr),
        .regWrData(regWrData), .regWrStrobe(regWrStrobe), .regRdStrobe(regRdStrobe),
        .regRdData_ff(regRdData_ff), .instrTick(instrTick), .internalFastOscillator(fastTick),
        .externalCountPin(externalCountPin), .globalIrqEnable(globalIrqEnable),
        .pwmBPinSel(pwmBPinSel), .pwmCPinSel(pwmCPinSel), .timerACount(timerACount),
        .timerAOverflow(timerAOverflow), .pwmPins_ff(pwmPins_ff),
        .timerDIrq_ff(timerDIrq_ff), .timerEIrq_ff(timerEIrq_ff));
    tbp_far_side u_far (.mclk(mclk), .externalCountPin(externalCountPin));

    task automatic chk(input logic [CNT_W-1:0] g, input logic [CNT_W-1:0] e);
        nCompared++;
        if (g !== e) begin
            errorCnt++;
            $display("Error at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] d);
        @(posedge mclk);
        regAddr <= a;
        regWrData <= d;
        regWrStrobe <= 1'b1;
        @(posedge mclk);
        regWrStrobe <= 1'b0;
    endtask
    task automatic rc(input logic [ADR_W-1:0] a, input logic [DAT_W-1:0] e);
        @(posedge mclk);
        regAddr <= a;
        regRdStrobe <= 1'b1;
        @(posedge mclk);
        regRdStrobe <= 1'b0;
        #1 chk({2'b00, regRdData_ff}, {2'b00, e});
    endtask
    task automatic cntChk(input int t, input logic [CNT_W-1:0] e);
        logic [DAT_W-1:0] h;
        @(posedge mclk);
        regAddr <= TMR_BASE[t];
        regRdStrobe <= 1'b1;
        @(posedge mclk);
        regAddr <= TMR_BASE[t] + OFS_LOW;
        #1 h = regRdData_ff;
        @(posedge mclk);
        regRdStrobe <= 1'b0;
        #1 chk({h[RLD_LSB[t]+:2], regRdData_ff}, e);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge mclk) instrTick <= 1'b1;
        @(posedge mclk) instrTick <= 1'b0;
    endtask
    task automatic pins(input logic [3:0] e);
        repeat (2) @(posedge mclk);
        #1 chk({6'h00, pwmPins_ff.bOut, pwmPins_ff.bOe}, {6'h00, e});
    endtask

    task automatic oneShotD();
        wr(5'h08, 8'h08);
        wr(5'h05, 8'h40);
        wr(5'h06, 8'h03);
        cntChk(TMR_D, 10'h103);
        wr(5'h11, 8'h04);
        wr(5'h07, 8'h05);
        tick(259);
        cntChk(TMR_D, 10'h000);
        rc(5'h11, 8'h04);
        tick(1);
        cntChk(TMR_D, 10'h103);
        rc(5'h07, 8'h04);
        rc(5'h11, 8'h44);
        chk({9'h000, timerDIrq_ff}, 10'h001);
        wr(5'h11, 8'h04);
        rc(5'h11, 8'h04);
        chk({9'h000, timerDIrq_ff}, 10'h000);
    endtask
    task automatic extEdgeE();
        wr(5'h0E, 8'h38);
        wr(5'h0B, 8'h00);
        wr(5'h0C, 8'h01);
        wr(5'h13, 8'h20);
        wr(5'h0D, 8'h01);
        u_far.pulse(1);
        cntChk(TMR_E, 10'h000);
        u_far.pulse(1);
        cntChk(TMR_E, 10'h3FF);
        rc(5'h12, 8'h20);
        chk({9'h000, timerEIrq_ff}, 10'h001);
    endtask
    task automatic prescaleD();
        wr(5'h08, 8'h00);
        wr(5'h05, 8'h00);
        wr(5'h06, 8'h10);
        wr(5'h07, 8'h03);
        tick(4);
        cntChk(TMR_D, 10'h00E);
        rc(5'h09, 8'h04);
        wr(5'h07, 8'h0B);
        @(posedge mclk) fastTick <= 1'b1;
        repeat (2) @(posedge mclk);
        fastTick <= 1'b0;
        cntChk(TMR_D, 10'h00D);
    endtask
    task automatic pwmB();
        rc(5'h1F, 8'h00);
        wr(5'h00, 8'h04);
        wr(5'h01, 8'h05);
        wr(5'h02, 8'h80);
        wr(5'h03, 8'h20);
        wr(5'h04, 8'h80);
        pins(4'b0001);
        @(posedge mclk) timerAOverflow <= 1'b1;
        @(posedge mclk) timerAOverflow <= 1'b0;
        pins(4'b0101);
        @(posedge mclk) timerACount <= 10'h106;
        pins(4'b0001);
        wr(5'h02, 8'hC0);
        pins(4'b0101);
        wr(5'h07, 8'hC0);
        @(posedge mclk) timerACount <= 10'h010;
        repeat (2) @(posedge mclk);
        #1 chk({2'b00, pwmPins_ff.cOut, pwmPins_ff.cOe, pwmPins_ff.dOut, pwmPins_ff.dOe,
                pwmPins_ff.eOut, pwmPins_ff.eOe}, 10'h05C);
    endtask
    task automatic printVerdict();
        $display("Compared %0d, errors %0d", nCompared, errorCnt);
        if (errorCnt == 0 && nCompared > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    initial begin
        repeat (3) @(posedge mclk);
        sys_rst <= 1'b0;
        oneShotD();
        extEdgeE();
        prescaleD();
        pwmB();
        printVerdict();
    end
endmodule // tbp_ten_bit_timers_tb_top
